// ===== hw/irq_ctrl_defines.svh
// register offset, bit positions, vectors and reset value of the irq block
// assumes inclusion by bare name from the design file
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_ADDR 8'h0B
`define IRQ_CTRL_RESET 8'h00
`define BIT_MASTER_EN 0
`define BIT_EXT_EN 1
`define BIT_T0_EN 2
`define BIT_T1_EN 3
`define BIT_EXT_FLAG 4
`define BIT_T0_FLAG 5
`define BIT_T1_FLAG 6
`define VEC_EXT 12'h004
`define VEC_T0 12'h008
`define VEC_T1 12'h00C
`define VEC_NONE 12'h000
`define PHASE_DIV 4
`endif

// ===== hw/irq_ctrl_pkg.sv
// types shared by the interrupt controller
// assumes irq_ctrl_defines.svh is on the include path
package irq_ctrl_pkg;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_wr_t;
   typedef struct packed {
      logic valid;
      logic [11:0] vector;
   } irq_req_t;
endpackage

// ===== hw/three_source_interrupt_controller.sv
// three-source interrupt controller: control register, flags, priority
// assumes core strobes ack one cycle before push_pc pushes the pc and it branches
// Overview of operation
// [RULE_01] taking timer1 clears its flag and master
// [RULE_02] nesting held until return or re-enabled
// [RULE_03] return_from_interrupt sets master, plain return not
// [RULE_04] requests sampled on second_clock_phase enable
// [RULE_05] priority external, timer0, timer1; 04H 08H 0CH
// [RULE_06] master enable clear masks all sources
// [RULE_07] master and source enables gate servicing
// [RULE_08] flags stay until serviced or cleared
// [RULE_09] control register bit layout at 0BH
// [RULE_10] falling pin edge sets external flag
// [RULE_11] timer0 overflow sets flag, service clears
// [RULE_12] only pc pushed, then branch to vector
// [RULE_13] no acknowledge while stack is full
// [RULE_14] reset clears all enables and flags
`include "irq_ctrl_defines.svh"
module three_source_interrupt_controller (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // data memory write and read of the control register
   input irq_ctrl_pkg::reg_wr_t reg_wr,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   // event sources
   input wire logic ext_irq_n,
   input wire logic timer0_ovf,
   input wire logic timer1_ovf,
   // core sequencer
   input wire logic stack_full,
   input wire logic return_from_interrupt,
   input wire logic plain_return,
   input wire logic irq_ack,
   output irq_ctrl_pkg::irq_req_t irq_req,
   output logic push_pc,
   output logic second_clock_phase
);
   logic [6:0] ctl_q;
   logic [6:0] ctl_d;
   logic [1:0] ext_sync_q;
   logic ext_last_q;
   logic [1:0] ph_cnt_q;
   logic fall;
   logic [2:0] pend;
   irq_ctrl_pkg::irq_req_t req_d;

   // pick highest priority pending source
   function automatic logic [11:0] vec_of(input logic [2:0] p);
      if (p[0]) vec_of = `VEC_EXT;
      else if (p[1]) vec_of = `VEC_T0;
      else if (p[2]) vec_of = `VEC_T1;
      else vec_of = `VEC_NONE;
   endfunction

   // pin synchroniser and edge detect
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ext_sync_q <= 2'b11;
         ext_last_q <= 1'b1;
      end else begin
         ext_sync_q <= {ext_sync_q[0], ext_irq_n};
         ext_last_q <= ext_sync_q[1];
      end
   end
   assign fall = ext_last_q & ~ext_sync_q[1]; // [RULE_10]

   // phase divider: one enable pulse every four clocks
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ph_cnt_q <= 2'h0;
         second_clock_phase <= 1'b0;
      end else begin
         ph_cnt_q <= ph_cnt_q + 2'h1;
         second_clock_phase <= (ph_cnt_q == 2'(`PHASE_DIV - 2));
      end
   end

   // enables gate flags; master masks all
   assign pend = ctl_q[6:4] & ctl_q[3:1] & {3{ctl_q[0]}}; // [RULE_06] [RULE_07]

   always_comb begin
      ctl_d = ctl_q;
      if (reg_wr.wr && reg_wr.addr == `IRQ_CTRL_ADDR)
         ctl_d = reg_wr.wdata[6:0]; // [RULE_09] [RULE_08]
      if (return_from_interrupt)
         ctl_d[`BIT_MASTER_EN] = 1'b1; // [RULE_03]
      if (irq_ack && irq_req.valid) begin
         ctl_d[`BIT_MASTER_EN] = 1'b0; // [RULE_02]
         unique case (irq_req.vector)
            `VEC_EXT: ctl_d[`BIT_EXT_FLAG] = 1'b0; // [RULE_10]
            `VEC_T0: ctl_d[`BIT_T0_FLAG] = 1'b0; // [RULE_11]
            `VEC_T1: ctl_d[`BIT_T1_FLAG] = 1'b0; // [RULE_01]
            default: ;
         endcase
      end
      // new events win over clears
      if (fall) ctl_d[`BIT_EXT_FLAG] = 1'b1; // [RULE_10]
      if (timer0_ovf) ctl_d[`BIT_T0_FLAG] = 1'b1; // [RULE_11]
      if (timer1_ovf) ctl_d[`BIT_T1_FLAG] = 1'b1;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) ctl_q <= 7'(`IRQ_CTRL_RESET); // [RULE_14]
      else ctl_q <= ctl_d;
   end

   always_comb begin
      req_d = irq_req;
      if (irq_ack && irq_req.valid) req_d.valid = 1'b0;
      else if (second_clock_phase) begin // [RULE_04]
         req_d.valid = |pend && !stack_full; // [RULE_13]
         req_d.vector = vec_of(pend); // [RULE_05]
      end
      if (!ctl_q[`BIT_MASTER_EN] || stack_full) req_d.valid = 1'b0;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_req <= '0;
         push_pc <= 1'b0;
         rd_data <= 8'h00;
      end else begin
         irq_req <= req_d;
         push_pc <= irq_ack && irq_req.valid; // [RULE_12]
         rd_data <= (rd_addr == `IRQ_CTRL_ADDR) ? {1'b0, ctl_q} : 8'h00;
      end
   end

   property p_master_off_on_ack;
      @(posedge core_clk) disable iff (rst)
      (irq_ack && irq_req.valid && !return_from_interrupt)
         |=> !ctl_q[`BIT_MASTER_EN];
   endproperty
   a_master_off_on_ack: assert property (p_master_off_on_ack) // [RULE_02]
      else $error("master enable not cleared on ack");

   property p_return_from_interrupt_sets;
      @(posedge core_clk) disable iff (rst)
      return_from_interrupt && !(irq_ack && irq_req.valid)
         |=> ctl_q[`BIT_MASTER_EN];
   endproperty
   a_return_from_interrupt_sets: assert property (p_return_from_interrupt_sets) // [RULE_03]
      else $error("return did not set master enable");

   property p_ret_keeps;
      @(posedge core_clk) disable iff (rst)
      plain_return && !return_from_interrupt && !irq_ack && !reg_wr.wr
         |=> ctl_q[`BIT_MASTER_EN] == $past(ctl_q[`BIT_MASTER_EN]);
   endproperty
   a_ret_keeps: assert property (p_ret_keeps) // [RULE_03]
      else $error("plain return changed master enable");

   property p_masked;
      @(posedge core_clk) disable iff (rst)
      !ctl_q[`BIT_MASTER_EN] |=> !irq_req.valid;
   endproperty
   a_masked: assert property (p_masked) // [RULE_06]
      else $error("request while master disabled");

   property p_stack_full;
      @(posedge core_clk) disable iff (rst)
      stack_full |=> !irq_req.valid;
   endproperty
   a_stack_full: assert property (p_stack_full) // [RULE_13]
      else $error("request while stack full");

   property p_ext_prio;
      @(posedge core_clk) disable iff (rst)
      second_clock_phase && pend[0] && !stack_full && !irq_req.valid
         |=> irq_req.valid && irq_req.vector == `VEC_EXT;
   endproperty
   a_ext_prio: assert property (p_ext_prio) // [RULE_05]
      else $error("external not taken first");

   property p_fall_sets;
      @(posedge core_clk) disable iff (rst)
      fall |=> ctl_q[`BIT_EXT_FLAG];
   endproperty
   a_fall_sets: assert property (p_fall_sets) // [RULE_10]
      else $error("falling edge lost");

   property p_flag_holds;
      @(posedge core_clk) disable iff (rst)
      ctl_q[`BIT_T0_FLAG] && !reg_wr.wr && !irq_ack
         |=> ctl_q[`BIT_T0_FLAG];
   endproperty
   a_flag_holds: assert property (p_flag_holds) // [RULE_08]
      else $error("timer0 flag dropped");

   property p_t1_clear;
      @(posedge core_clk) disable iff (rst)
      irq_ack && irq_req.valid && irq_req.vector == `VEC_T1 && !timer1_ovf
         |=> !ctl_q[`BIT_T1_FLAG] && push_pc;
   endproperty
   a_t1_clear: assert property (p_t1_clear) // [RULE_01]
      else $error("timer1 service did not clear");

   property p_phase_only;
      @(posedge core_clk) disable iff (rst)
      !irq_req.valid && !second_clock_phase |=> !irq_req.valid;
   endproperty
   a_phase_only: assert property (p_phase_only) // [RULE_04]
      else $error("request raised off phase");

   property p_ext_clear;
      @(posedge core_clk) disable iff (rst)
      irq_ack && irq_req.valid && irq_req.vector == `VEC_EXT && !fall
         |=> !ctl_q[`BIT_EXT_FLAG] && !ctl_q[`BIT_MASTER_EN];
   endproperty
   a_ext_clear: assert property (p_ext_clear) // [RULE_10]
      else $error("external service did not clear");

   property p_t0_clear;
      @(posedge core_clk) disable iff (rst)
      irq_ack && irq_req.valid && irq_req.vector == `VEC_T0 && !timer0_ovf
         |=> !ctl_q[`BIT_T0_FLAG] && push_pc;
   endproperty
   a_t0_clear: assert property (p_t0_clear) // [RULE_11]
      else $error("timer0 service did not clear");

   property p_push_only_on_ack;
      @(posedge core_clk) disable iff (rst)
      !(irq_ack && irq_req.valid) |=> !push_pc;
   endproperty
   a_push_only_on_ack: assert property (p_push_only_on_ack) // [RULE_12]
      else $error("pc pushed without acknowledge");

   // phase enable repeats every four clocks
   property p_phase_period;
      @(posedge core_clk) disable iff (rst)
      second_clock_phase
         |=> !second_clock_phase ##1 !second_clock_phase
            ##1 !second_clock_phase ##1 second_clock_phase;
   endproperty
   a_phase_period: assert property (p_phase_period) // [RULE_04]
      else $error("phase pulse spacing wrong");
endmodule // three_source_interrupt_controller

// ===== verification/core_model.sv
// partner model of the core sequencer: takes pending requests
// assumes irq_req timing of the controller and the bench's ack_en
module core_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // controller side
   input irq_ctrl_pkg::irq_req_t irq_req,
   input wire logic ack_en,
   output logic irq_ack,
   output logic [11:0] taken_vec
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_ack <= 1'b0;
         taken_vec <= 12'h000;
      end else begin
         irq_ack <= irq_req.valid & ack_en & ~irq_ack;
         if (irq_req.valid & ack_en & ~irq_ack) begin
            taken_vec <= irq_req.vector;
         end
      end
   end
endmodule // core_model

// ===== verification/tb.sv
// self-checking bench of the three-source interrupt controller
// assumes the package, the design and the core model compiled first
`define CHK(n, e, a) total_checks++; if ((a) !== (e)) begin \
   $display("[FAIL] %s exp %h got %h", n, e, a); \
   miscompares++; end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst, ext_irq_n, timer0_ovf, timer1_ovf, stack_full;
   logic return_from_interrupt, plain_return, irq_ack, push_pc, ack_en;
   logic second_clock_phase;
   logic [7:0] rd_addr, rd_data;
   logic [11:0] taken_vec;
   irq_ctrl_pkg::reg_wr_t reg_wr;
   irq_ctrl_pkg::irq_req_t irq_req;
   int miscompares = 0;
   int total_checks = 0;
   three_source_interrupt_controller three_source_interrupt_controller_inst (
      .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .rd_addr(rd_addr),
      .rd_data(rd_data), .ext_irq_n(ext_irq_n), .timer0_ovf(timer0_ovf),
      .timer1_ovf(timer1_ovf), .stack_full(stack_full),
      .return_from_interrupt(return_from_interrupt),
      .plain_return(plain_return), .irq_ack(irq_ack), .irq_req(irq_req),
      .push_pc(push_pc), .second_clock_phase(second_clock_phase));
   core_model core_model_inst (.core_clk(core_clk), .rst(rst),
      .irq_req(irq_req), .ack_en(ack_en), .irq_ack(irq_ack),
      .taken_vec(taken_vec));
   task automatic tick(int n);
      repeat (n) @(posedge core_clk);
      #5;
   endtask
   task automatic wr(logic [7:0] d);
      reg_wr = '{1'b1, 8'h0B, d};
      tick(1);
      reg_wr.wr = 1'b0;
   endtask
   task automatic rd(string n, logic [7:0] e);
      tick(2);
      `CHK(n, e, rd_data)
   endtask
   task automatic wait_push(string n, logic [11:0] v);
      int i;
      for (i = 0; i < 40 && push_pc !== 1'b1; i++) tick(1);
      `CHK("push_pc", 1'b1, push_pc)
      `CHK(n, v, taken_vec)
   endtask
   task automatic t_reset();
      int i;
      rd("reset", 8'h00);
      rd_addr = 8'h0C;
      wr(8'h8F);
      rd("unmapped", 8'h00);
      rd_addr = 8'h0B;
      rd("layout", 8'h0F);
      for (i = 0; i < 8 && second_clock_phase !== 1'b1; i++) tick(1);
      `CHK("phase_on", 1'b1, second_clock_phase)
      tick(1);
      `CHK("phase_off", 1'b0, second_clock_phase)
      tick(3);
      `CHK("phase_again", 1'b1, second_clock_phase)
      $display("test reset_layout done");
   endtask
   task automatic t_prio();
      wr(8'h0E);
      ext_irq_n = 1'b0;
      timer0_ovf = 1'b1;
      timer1_ovf = 1'b1;
      tick(1);
      timer0_ovf = 1'b0;
      timer1_ovf = 1'b0;
      tick(10);
      rd("masked", 8'h7E);
      `CHK("no_req", 1'b0, irq_req.valid)
      wr(8'h7F);
      wait_push("ext_vec", 12'h004);
      rd("ext_clr", 8'h6E);
      ext_irq_n = 1'b1;
      return_from_interrupt = 1'b1;
      tick(1);
      return_from_interrupt = 1'b0;
      wait_push("t0_vec", 12'h008);
      rd("t0_clr", 8'h4E);
      plain_return = 1'b1;
      tick(1);
      plain_return = 1'b0;
      tick(10);
      rd("ret", 8'h4E);
      wr(8'h4F);
      wait_push("t1_vec", 12'h00C);
      rd("t1_clr", 8'h0E);
      $display("test priority done");
   endtask
   task automatic t_stack();
      stack_full = 1'b1;
      wr(8'h05);
      timer0_ovf = 1'b1;
      timer1_ovf = 1'b1;
      tick(1);
      timer0_ovf = 1'b0;
      timer1_ovf = 1'b0;
      tick(12);
      rd("full", 8'h65);
      `CHK("full_noreq", 1'b0, irq_req.valid)
      stack_full = 1'b0;
      wait_push("late_vec", 12'h008);
      rd("after", 8'h44);
      wr(8'h00);
      rd("sw_clr", 8'h00);
      wr(8'h0F);
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      rd("rst_again", 8'h00);
      $display("test stack_full done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      rst = 1'b1;
      ext_irq_n = 1'b1;
      timer0_ovf = 1'b0;
      timer1_ovf = 1'b0;
      stack_full = 1'b0;
      return_from_interrupt = 1'b0;
      plain_return = 1'b0;
      reg_wr = '0;
      rd_addr = 8'h0B;
      ack_en = 1'b1;
      tick(2);
      rst = 1'b0;
      t_reset();
      t_prio();
      t_stack();
      close_out();
   end
   initial begin
      #(50 * 3000);
      miscompares++;
      close_out();
   end
endmodule // tb
